// file: bench/twr_sva.sv
`timescale 1ns/1ps
module twr_sva (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic sclk,
	input wire logic sdat,
	input wire logic sclk_oe,
	input wire logic sdat_m_oe,
	input wire logic sdat_s_oe
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// Clock rises seen while the device keeps pulling data low
	logic [3:0] drv_cnt_reg;
	logic [3:0] drv_cnt_next;
	logic sclk_d_reg;
	always_comb begin
		drv_cnt_next = drv_cnt_reg;
		if (!sdat_s_oe) begin
			drv_cnt_next = 4'h_0;
		end else if (sclk && !sclk_d_reg) begin
			drv_cnt_next = drv_cnt_reg + 4'h_1;
		end
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			drv_cnt_reg <= 4'h_0;
			sclk_d_reg <= 1'b1;
		end else begin
			drv_cnt_reg <= drv_cnt_next;
			sclk_d_reg <= sclk;
		end
	end
	dev_data_stable_a: assert property (
		$changed(sdat_s_oe) |-> !sclk) else $error("device data moved with clock high");
	no_contention_a: assert property (
		!(sdat_s_oe && sdat_m_oe)) else $error("both ends drive data");
	clk_low_host_a: assert property (
		$fell(sclk) |-> sclk_oe [*8]) else $error("clock low not from host");
	clk_high_min_a: assert property (
		$rose(sclk) |-> sclk [*8]) else $error("clock high phase too short");
	stop_release_a: assert property (
		$rose(sdat) && sclk |-> (sclk && !sdat_s_oe) [*8])
		else $error("bus not released at stop");
	start_hold_a: assert property (
		$fell(sdat) && sclk |-> sclk [*4]) else $error("start not held");
	drive_span_a: assert property (
		drv_cnt_reg <= 4'h_9) else $error("device drove beyond one byte");
	ack_after_fall_a: assert property (
		$rose(sdat_s_oe) |-> !sclk && !$past(sclk, 2))
		else $error("device drive not after clock fall");
	cover property ($rose(sdat_s_oe));
	cover property ($rose(sdat) && sclk);
	cover property ($fell(sdat) && sclk && !sdat_s_oe);
endmodule

// file: bench/twr_tb_top.sv
`timescale 1ns/1ps
module twr_tb_top;
	logic core_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic fast_i = 1'b1;
	logic req_i = 1'b0;
	logic [2:0] dev_addr_i = 3'h_3;
	logic rw_i = 1'b0;
	logic [7:0] byte_i = 8'h_00;
	logic [7:0] data_i = 8'h_00;
	logic restart_i = 1'b0;
	// Pins give the low address bits of the slave
	logic [2:0] addr_pins_i = 3'h_3;
	logic busy_o;
	logic done_o;
	logic nack_o;
	logic wr_stb_o;
	logic [7:0] rd_data_o;
	logic [7:0] reg_addr_o;
	logic [7:0] wr_data_o;
	logic [7:0] dev_rd_data;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	int n_stb = 0;
	twr_bus_if twr_bus_if_i ();
	twr_dev twr_dev_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.bus(twr_bus_if_i.dev), .addr_pins_i(addr_pins_i),
		.reg_addr_o(reg_addr_o), .wr_data_o(wr_data_o),
		.wr_stb_o(wr_stb_o), .rd_data_o(dev_rd_data));
	twr_host twr_host_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.bus(twr_bus_if_i.host), .fast_i(fast_i), .req_i(req_i),
		.dev_addr_i(dev_addr_i), .rw_i(rw_i), .byte_i(byte_i),
		.data_i(data_i), .restart_i(restart_i), .busy_o(busy_o),
		.done_o(done_o), .nack_o(nack_o), .rd_data_o(rd_data_o));
	twr_sva twr_sva_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
		.sclk(twr_bus_if_i.sclk), .sdat(twr_bus_if_i.sdat),
		.sclk_oe(twr_bus_if_i.sclk_oe), .sdat_m_oe(twr_bus_if_i.sdat_m_oe),
		.sdat_s_oe(twr_bus_if_i.sdat_s_oe));
	always #2 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		if (wr_stb_o === 1'b1) begin
			n_stb++;
		end
	end
	// Whole run is near 94k cycles, nearly half of it the slow transfer
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 99000) begin
			n_errors++;
			$display("CHECK FAILED at %0t: run timed out", $time);
			test_done();
		end
	end
	task automatic test_done();
		$display("mismatches %0d of %0d compares", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s %b not %b", $time, what, got, exp);
		end
	endtask
	// Request held until busy, so a level request cannot start twice
	task automatic xfer(input logic rw, input logic [2:0] dev,
		input logic [7:0] ptr, input logic [7:0] dat, input logic rs);
		int n;
		n = 0;
		@(negedge core_clk_i);
		rw_i = rw;
		dev_addr_i = dev;
		byte_i = ptr;
		data_i = dat;
		restart_i = rs;
		req_i = 1'b1;
		while (done_o !== 1'b1 && n < 60000) begin
			@(negedge core_clk_i);
			n++;
			if (busy_o === 1'b1) begin
				req_i = 1'b0;
			end
		end
	endtask
	initial begin
		repeat (4) @(negedge core_clk_i);
		arst_n_i = 1'b1;
		xfer(1'b0, 3'h_3, 8'h_6d, 8'h_92, 1'b1);
		chk1(nack_o, 1'b0, "write ack");
		chk8(reg_addr_o, 8'h_6d, "pointer");
		chk8(wr_data_o, 8'h_92, "stored byte");
		chk8(dev_rd_data, 8'h_92, "device port");
		$display("test write done");
		xfer(1'b1, 3'h_3, 8'h_00, 8'h_00, 1'b0);
		chk1(nack_o, 1'b0, "read ack");
		chk8(rd_data_o, 8'h_92, "read byte");
		$display("test restart read done");
		xfer(1'b0, 3'h_2, 8'h_11, 8'h_5a, 1'b0);
		chk1(nack_o, 1'b1, "foreign address");
		chk8(reg_addr_o, 8'h_6d, "pointer kept");
		xfer(1'b1, 3'h_3, 8'h_00, 8'h_00, 1'b0);
		chk8(rd_data_o, 8'h_92, "reread");
		$display("test foreign address done");
		fast_i = 1'b0;
		xfer(1'b1, 3'h_7, 8'h_00, 8'h_00, 1'b0);
		chk1(nack_o, 1'b1, "slow foreign read");
		chk8(8'(n_stb), 8'h_01, "store strobes");
		chk1(twr_bus_if_i.sdat, 1'b1, "data idle");
		chk1(twr_bus_if_i.sclk, 1'b1, "clock idle");
		$display("test slow rate done");
		test_done();
	end
endmodule

// file: rtl/twr_bus_if.sv
`timescale 1ns/1ps
interface twr_bus_if;
	logic sclk_o;
	logic sclk_oe;
	logic sdat_m_o;
	logic sdat_m_oe;
	logic sdat_s_o;
	logic sdat_s_oe;
	logic sclk;
	logic sdat;
	// Open-drain wired-AND with pull-ups
	assign sclk = !(sclk_oe && !sclk_o);
	assign sdat = !((sdat_m_oe && !sdat_m_o) || (sdat_s_oe && !sdat_s_o));
	assign sdat_s_o = 1'b0;
	assign sdat_m_o = 1'b0;
	modport dev (input sclk, input sdat, output sdat_s_oe);
	modport host (input sclk, input sdat, output sclk_oe, output sclk_o,
		output sdat_m_oe);
endinterface

// file: rtl/twr_dev.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Slave only; never drives serial clock
// RULE2 - Address is 1010 plus three pins
// RULE3 - Works at standard and fast rates
// RULE4 - Start/stop are data edges, clock high
// RULE5 - Write direction address is acknowledged
// RULE6 - Register address byte then acknowledged
// RULE7 - Data byte stored and acknowledged
// RULE8 - Then stop or repeated start
// RULE9 - Register pointer held until rewritten
// RULE10 - Read: set pointer, restart, direction one
// RULE11 - Shift out selected register, MSB first
// RULE12 - Master acknowledges read byte, then ends
// RULE13 - Restart: data high, clock high, data low
// RULE14 - Drive data only for ack/read byte
// RULE15 - Mismatch: no ack, ignore until start
module twr_dev (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	twr_bus_if.dev bus,
	input wire logic [2:0] addr_pins_i,
	output logic [7:0] reg_addr_o,
	output logic [7:0] wr_data_o,
	output logic wr_stb_o,
	output logic [7:0] rd_data_o
);
	typedef enum logic [2:0] {
		TWR_IDLE = 3'b000,
		TWR_DADDR = 3'b001,
		TWR_RADDR = 3'b010,
		TWR_WDATA = 3'b011,
		TWR_RDATA = 3'b100,
		TWR_MACK = 3'b101
	} twr_state_t;
	twr_state_t state_reg, state_next;
	logic [1:0] scl_sync_reg, sda_sync_reg;
	logic scl_d_reg, sda_d_reg;
	logic [7:0] sh_reg, sh_next;
	logic [3:0] cnt_reg, cnt_next;
	logic ack_reg, ack_next;
	logic rw_reg, rw_next;
	logic [7:0] ptr_reg, ptr_next;
	logic [7:0] wd_reg, wd_next;
	logic stb_reg, stb_next;
	logic drive_reg, drive_next;
	logic [7:0] mem [0:twr_pkg::NREGS-1];
	logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
	// Two flops before use; the pin is asynchronous to core_clk_i
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			scl_sync_reg <= 2'b11;
			sda_sync_reg <= 2'b11;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], bus.sclk};
			sda_sync_reg <= {sda_sync_reg[0], bus.sdat};
			scl_d_reg <= scl_sync_reg[1];
			sda_d_reg <= sda_sync_reg[1];
		end
	end
	assign scl = scl_sync_reg[1];
	assign sda = sda_sync_reg[1];
	// Oversampling at 4 ns keeps both bus rates well resolved
	assign scl_rise = scl && !scl_d_reg; // RULE3
	assign scl_fall = !scl && scl_d_reg;
	assign start_c = scl && scl_d_reg && sda_d_reg && !sda; // RULE4 RULE13
	assign stop_c = scl && scl_d_reg && !sda_d_reg && sda; // RULE4
	always_comb begin
		state_next = state_reg;
		sh_next = sh_reg;
		cnt_next = cnt_reg;
		ack_next = ack_reg;
		rw_next = rw_reg;
		ptr_next = ptr_reg;
		wd_next = wd_reg;
		stb_next = 1'b0;
		drive_next = drive_reg;
		if (start_c) begin
			state_next = TWR_DADDR; // RULE8 RULE13
			cnt_next = 4'h_0;
			ack_next = 1'b0;
			drive_next = 1'b0;
		end else if (stop_c) begin
			state_next = TWR_IDLE; // RULE8
			drive_next = 1'b0;
		end else begin
			case (state_reg)
			TWR_IDLE: begin
				drive_next = 1'b0; // RULE15
			end
			TWR_DADDR, TWR_RADDR, TWR_WDATA: begin
				if (!ack_reg && scl_rise) begin
					sh_next = {sh_reg[6:0], sda}; // RULE2 RULE6 RULE7
					cnt_next = cnt_reg + 4'h_1;
				end
				if (!ack_reg && scl_fall && cnt_reg == 4'h_8) begin
					ack_next = 1'b1;
					cnt_next = 4'h_0;
					if (state_reg == TWR_DADDR) begin
						if (sh_reg[7:1] == {twr_pkg::ADDR_HI, addr_pins_i}) begin
							rw_next = sh_reg[0]; // RULE2
							drive_next = 1'b1; // RULE5 RULE10
						end else begin
							state_next = TWR_IDLE; // RULE15
						end
					end else if (state_reg == TWR_RADDR) begin
						ptr_next = sh_reg; // RULE9
						drive_next = 1'b1; // RULE6
					end else begin
						wd_next = sh_reg;
						stb_next = 1'b1; // RULE7
						drive_next = 1'b1;
					end
				end else if (ack_reg && scl_fall) begin
					ack_next = 1'b0;
					drive_next = 1'b0; // RULE14
					if (state_reg == TWR_DADDR && rw_reg == twr_pkg::RW_READ) begin
						state_next = TWR_RDATA; // RULE11
						sh_next = mem[ptr_reg];
						drive_next = !mem[ptr_reg][7];
						cnt_next = 4'h_0;
					end else if (state_reg == TWR_DADDR) begin
						state_next = TWR_RADDR;
					end else begin
						state_next = TWR_WDATA;
					end
				end
			end
			TWR_RDATA: begin
				if (scl_fall) begin
					cnt_next = cnt_reg + 4'h_1;
					sh_next = {sh_reg[6:0], 1'b0};
					if (cnt_reg == 4'h_7) begin
						state_next = TWR_MACK; // RULE12
						drive_next = 1'b0;
					end else begin
						drive_next = !sh_reg[6]; // RULE11 RULE14
					end
				end
			end
			TWR_MACK: begin
				// No second byte: a low bit here would block the stop
				if (scl_fall) begin
					state_next = TWR_IDLE; // RULE12
					drive_next = 1'b0; // RULE14
					cnt_next = 4'h_0;
					ack_next = 1'b0;
				end
			end
			default: begin
				state_next = TWR_IDLE;
			end
			endcase
		end
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= TWR_IDLE;
			sh_reg <= 8'h_00;
			cnt_reg <= 4'h_0;
			ack_reg <= 1'b0;
			rw_reg <= 1'b0;
			ptr_reg <= 8'h_00;
			wd_reg <= 8'h_00;
			stb_reg <= 1'b0;
			drive_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sh_reg <= sh_next;
			cnt_reg <= cnt_next;
			ack_reg <= ack_next;
			rw_reg <= rw_next;
			ptr_reg <= ptr_next;
			wd_reg <= wd_next;
			stb_reg <= stb_next;
			drive_reg <= drive_next;
		end
	end
	// Register array has no reset so it maps onto plain storage
	always_ff @(posedge core_clk_i) begin
		if (stb_next) begin
			mem[ptr_reg] <= sh_reg; // RULE7
		end
	end
	// Pulls low only; the clock pin is never an output here
	assign bus.sdat_s_oe = drive_reg; // RULE1 RULE14
	assign reg_addr_o = ptr_reg;
	assign wr_data_o = wd_reg;
	assign wr_stb_o = stb_reg;
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_o <= twr_pkg::REG_RESET;
		end else begin
			rd_data_o <= mem[ptr_reg];
		end
	end
endmodule

// file: rtl/twr_host.sv
`timescale 1ns/1ps
module twr_host (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	twr_bus_if.host bus,
	input wire logic fast_i,
	input wire logic req_i,
	input wire logic [2:0] dev_addr_i,
	input wire logic rw_i,
	input wire logic [7:0] byte_i,
	input wire logic [7:0] data_i,
	input wire logic restart_i,
	output logic busy_o,
	output logic done_o,
	output logic nack_o,
	output logic [7:0] rd_data_o
);
	typedef enum logic [2:0] {
		TWH_IDLE = 3'b000,
		TWH_START = 3'b001,
		TWH_BITS = 3'b010,
		TWH_STOP = 3'b011,
		TWH_HOLD = 3'b100
	} twh_state_t;
	twh_state_t state_reg, state_next;
	logic [11:0] div_reg, div_next;
	logic [1:0] ph_reg, ph_next;
	logic [3:0] bit_reg, bit_next;
	logic [1:0] byte_reg, byte_next;
	logic [7:0] sh_reg, sh_next;
	logic scl_reg, scl_next, sda_reg, sda_next;
	logic nack_reg, nack_next, done_reg, done_next;
	logic [7:0] rd_reg, rd_next;
	logic [1:0] sda_sync_reg;
	logic tick;
	logic [1:0] nbytes;
	logic [11:0] half;
	assign half = fast_i ? 12'(twr_pkg::FAST_HALF) : 12'(twr_pkg::STD_HALF);
	assign tick = (div_reg == 12'h_000);
	// A read is the address byte plus the returned byte
	assign nbytes = (rw_i == twr_pkg::RW_READ) ? 2'h_2 : 2'h_3; // RULE10
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sda_sync_reg <= 2'b11;
		end else begin
			sda_sync_reg <= {sda_sync_reg[0], bus.sdat};
		end
	end
	always_comb begin
		state_next = state_reg;
		div_next = tick ? (half >> 1) : div_reg - 12'h_001;
		ph_next = ph_reg;
		bit_next = bit_reg;
		byte_next = byte_reg;
		sh_next = sh_reg;
		scl_next = scl_reg;
		sda_next = sda_reg;
		nack_next = nack_reg;
		done_next = 1'b0;
		rd_next = rd_reg;
		case (state_reg)
		TWH_IDLE, TWH_HOLD: begin
			if (req_i && tick) begin
				state_next = TWH_START;
				ph_next = 2'd0;
				nack_next = 1'b0;
			end
		end
		TWH_START: begin
			if (tick) begin
				ph_next = ph_reg + 2'd1;
				case (ph_reg)
				2'd0: sda_next = 1'b1;
				2'd1: scl_next = 1'b1;
				2'd2: sda_next = 1'b0; // RULE4 RULE13
				default: begin
					scl_next = 1'b0;
					state_next = TWH_BITS;
					sh_next = {twr_pkg::ADDR_HI, dev_addr_i, rw_i}; // RULE2 RULE5
					bit_next = 4'h_0;
					byte_next = 2'd0;
				end
				endcase
			end
		end
		TWH_BITS: begin
			if (tick) begin
				ph_next = ph_reg + 2'd1;
				case (ph_reg)
				2'd0: begin
					if (bit_reg == 4'h_8) begin
						// Ack slot: release unless acking a read byte
						sda_next = !(rw_i && byte_reg == 2'd1); // RULE12
					end else if (rw_i && byte_reg == 2'd1) begin
						sda_next = 1'b1;
					end else begin
						sda_next = sh_reg[7]; // RULE6 RULE7
					end
				end
				2'd1: scl_next = 1'b1;
				2'd2: begin
					if (bit_reg == 4'h_8 && !(rw_i && byte_reg == 2'd1)) begin
						nack_next = nack_reg | sda_sync_reg[1];
					end else if (bit_reg != 4'h_8) begin
						rd_next = {rd_reg[6:0], sda_sync_reg[1]};
					end
					if (bit_reg == 4'h_8 && rw_i && byte_reg == 2'd1) begin
						nack_next = nack_reg;
					end
				end
				default: begin
					scl_next = 1'b0;
					sh_next = {sh_reg[6:0], 1'b0};
					bit_next = bit_reg + 4'h_1;
					if (bit_reg == 4'h_8) begin
						bit_next = 4'h_0;
						byte_next = byte_reg + 2'd1;
						sh_next = (byte_reg == 2'd0) ? byte_i : data_i;
						if (byte_reg + 2'd1 == nbytes || nack_reg) begin
							state_next = TWH_STOP;
						end
					end
				end
				endcase
			end else if (ph_reg == 2'd0 && bit_reg == 4'h_8 &&
				!(rw_i && byte_reg == 2'd1)) begin
				// Let go a cycle after the clock falls, ahead of the slave ack
				sda_next = 1'b1;
			end
		end
		TWH_STOP: begin
			if (tick) begin
				ph_next = ph_reg + 2'd1;
				case (ph_reg)
				2'd0: sda_next = !restart_i ? 1'b0 : 1'b1;
				2'd1: scl_next = 1'b1;
				2'd2: sda_next = 1'b1; // RULE4 RULE8
				default: begin
					done_next = 1'b1;
					state_next = restart_i ? TWH_HOLD : TWH_IDLE;
				end
				endcase
			end
		end
		default: state_next = TWH_IDLE;
		endcase
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg <= TWH_IDLE;
			div_reg <= 12'h_000;
			ph_reg <= 2'd0;
			bit_reg <= 4'h_0;
			byte_reg <= 2'd0;
			sh_reg <= 8'h_00;
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
			nack_reg <= 1'b0;
			done_reg <= 1'b0;
			rd_reg <= 8'h_00;
		end else begin
			state_reg <= state_next;
			div_reg <= div_next;
			ph_reg <= ph_next;
			bit_reg <= bit_next;
			byte_reg <= byte_next;
			sh_reg <= sh_next;
			scl_reg <= scl_next;
			sda_reg <= sda_next;
			nack_reg <= nack_next;
			done_reg <= done_next;
			rd_reg <= rd_next;
		end
	end
	assign bus.sclk_o = scl_reg;
	assign bus.sclk_oe = !scl_reg; // RULE1
	assign bus.sdat_m_oe = !sda_reg;
	assign busy_o = (state_reg != TWH_IDLE) && (state_reg != TWH_HOLD);
	assign done_o = done_reg;
	assign nack_o = nack_reg;
	assign rd_data_o = rd_reg;
endmodule

// file: rtl/twr_pkg.sv
package twr_pkg;
	// Fixed upper part of the seven-bit slave address
	localparam logic [3:0] ADDR_HI = 4'h_a;
	localparam int unsigned CLK_MHZ = 250;
	// Standard and fast bus rates, kHz
	localparam int unsigned STD_KHZ = 64;
	localparam int unsigned FAST_KHZ = 400;
	// Half bit period in core cycles for the master's clock divider
	localparam int unsigned FAST_HALF = (CLK_MHZ * 1000) / (FAST_KHZ * 2);
	localparam int unsigned STD_HALF = (CLK_MHZ * 1000) / (STD_KHZ * 2);
	localparam int unsigned HALF_W = 12;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;
	localparam int unsigned NREGS = 256;
	localparam logic [7:0] REG_RESET = 8'h_00;
endpackage
